/* pkg/dshfc_defines.vh */
// Purpose: Constants for the dual-slot hot-plug fault control block.
// Assumes: 50 MHz clock on MCLK_I; all times given in milliseconds.
// Notes: Behaviour
`ifndef DSHFC_DEFINES_VH
`define DSHFC_DEFINES_VH
`define DSHFC_CLK_KHZ 50000
`define DSHFC_TRIP_MS 40
`define DSHFC_RETRY_MS 820
`define DSHFC_DEBOUNCE_MS 10
`define DSHFC_DELAY_OK_MS 164
`define DSHFC_CNT_W 26
`define DSHFC_ADDR_CTRL 4'h0
`define DSHFC_ADDR_STATUS 4'h4
`define DSHFC_CTRL_RETRY_BIT 0
`define DSHFC_CTRL_RESET 32'h00000000
`define DSHFC_ST_MAIN_TRIP 0
`define DSHFC_ST_AUX_TRIP 2
`define DSHFC_ST_CARD 4
`define DSHFC_ST_POWER_OK 6
`define DSHFC_ST_DELAY_OK 8
`define DSHFC_ST_FORCE 10
`endif

/* design/dshfc_top.v */
// Purpose: Fault, trip-timer, debounce and status logic for two hot-plug slots.
// Assumes: All inputs synchronous to MCLK_I; analog events arrive as levels.
// Notes: Open-drain outputs are given as drive enables; high pulls the pin low.
`timescale 1ns/1ps
`include "dshfc_defines.vh"
module dshfc_top #(
   parameter CNT_W = `DSHFC_CNT_W,
   parameter [`DSHFC_CNT_W-1:0] TRIP_CYC = `DSHFC_TRIP_MS * `DSHFC_CLK_KHZ,
   parameter [`DSHFC_CNT_W-1:0] RETRY_CYC = `DSHFC_RETRY_MS * `DSHFC_CLK_KHZ,
   parameter [`DSHFC_CNT_W-1:0] DEBOUNCE_CYC = `DSHFC_DEBOUNCE_MS * `DSHFC_CLK_KHZ,
   parameter [`DSHFC_CNT_W-1:0] DELAY_OK_CYC = `DSHFC_DELAY_OK_MS * `DSHFC_CLK_KHZ
)(
   input wire MCLK_I,
   input wire RESET_I,
   input wire [3:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   output reg [31:0] AVS_READDATA_O,
   output reg AVS_WAITREQUEST_O,
   input wire [1:0] MAIN_ENABLE_I,
   input wire [1:0] SLOT_STANDBY_ENABLE_I,
   input wire [1:0] CARD_LATCH_N_I,
   input wire [1:0] FORCE_ON_N_I,
   input wire [1:0] MAIN_OC_SLOW_I,
   input wire [1:0] MAIN_OC_FAST_I,
   input wire [1:0] AUX_OC_I,
   input wire [1:0] FILTER_CAP_TIMEOUT_I,
   input wire [1:0] FILTER_CAP_PIN_GROUNDED_I,
   input wire [1:0] MAIN_INPUT_UV_I,
   input wire [1:0] STANDBY_SUPPLY_IN_UV_I,
   input wire [1:0] MAIN_HIGH_RAIL_GOOD_I,
   input wire [1:0] MAIN_LOW_RAIL_GOOD_I,
   input wire [1:0] STANDBY_RAIL_GOOD_I,
   input wire [1:0] SLOT_HOT_I,
   input wire DIE_HOT_I,
   output reg [1:0] MAIN_HIGH_RAIL_OUT_EN_O,
   output reg [1:0] MAIN_LOW_RAIL_OUT_EN_O,
   output reg [1:0] STANDBY_RAIL_OUT_EN_O,
   output reg [1:0] MAIN_FAULT_OE_O,
   output reg [1:0] AUX_FAULT_OE_O,
   output reg [1:0] SLOT_POWER_OK_N_OE_O,
   output reg [1:0] DELAYED_POWER_OK_N_OE_O,
   output reg SYSTEM_POWER_OK_OE_O,
   output reg ALERT_OE_O
);

   reg auto_retry_reg;
   reg [1:0] main_en_d_reg;
   reg [1:0] aux_en_d_reg;
   reg [1:0] card_reg;
   reg [1:0] main_trip_reg;
   reg [1:0] aux_trip_reg;
   reg [1:0] alert_reg;
   reg [1:0] power_ok_reg;
   reg [1:0] delay_ok_reg;
   reg [CNT_W-1:0] deb_cnt_reg [0:1];
   reg [CNT_W-1:0] main_tmr_reg [0:1];
   reg [CNT_W-1:0] aux_tmr_reg [0:1];
   reg [CNT_W-1:0] retry_tmr_reg [0:1];
   reg [CNT_W-1:0] dly_tmr_reg [0:1];
   wire [1:0] force_on;
   wire [1:0] main_fall;
   wire [1:0] aux_fall;
   wire [1:0] rails_good;
   reg [1:0] main_trip_now;
   reg [1:0] aux_trip_now;
   reg [1:0] retry_done;
   reg [1:0] main_gate;
   reg [1:0] aux_gate;
   reg [1:0] slot_bad;
   reg [31:0] status_word;
   localparam [31:0] CTRL_RST = `DSHFC_CTRL_RESET;

   // Saturating count while the condition holds, restart from zero otherwise.
   function [`DSHFC_CNT_W-1:0] step;
      input run;
      input [`DSHFC_CNT_W-1:0] cnt;
      input [`DSHFC_CNT_W-1:0] lim;
      begin
         if (!run)
         begin
            step = {`DSHFC_CNT_W{1'b0}};
         end
         else if (cnt < lim)
         begin
            step = cnt + 1'b1;
         end
         else
         begin
            step = cnt;
         end
      end
   endfunction

   assign force_on = ~FORCE_ON_N_I;
   assign main_fall = main_en_d_reg & ~MAIN_ENABLE_I;
   assign aux_fall = aux_en_d_reg & ~SLOT_STANDBY_ENABLE_I;
   assign rails_good = MAIN_HIGH_RAIL_GOOD_I & MAIN_LOW_RAIL_GOOD_I & STANDBY_RAIL_GOOD_I;

   always @*
   begin : slot_comb_blk
      integer i;
      i = 0;
      for (i = 0; i < 2; i = i + 1)
      begin
         // Analog timeout counts only when a filter capacitor is fitted.
         main_trip_now[i] = !force_on[i] && MAIN_ENABLE_I[i] && (MAIN_OC_FAST_I[i]
            || (MAIN_OC_SLOW_I[i] && main_tmr_reg[i] >= TRIP_CYC)
            || (MAIN_OC_SLOW_I[i] && FILTER_CAP_TIMEOUT_I[i]
                && !FILTER_CAP_PIN_GROUNDED_I[i])
            || MAIN_INPUT_UV_I[i]);
         aux_trip_now[i] = !force_on[i] && SLOT_STANDBY_ENABLE_I[i] && (DIE_HOT_I
            || (AUX_OC_I[i] && SLOT_HOT_I[i])
            || (AUX_OC_I[i] && aux_tmr_reg[i] >= TRIP_CYC)
            || (AUX_OC_I[i] && FILTER_CAP_TIMEOUT_I[i]
                && !FILTER_CAP_PIN_GROUNDED_I[i]));
         retry_done[i] = auto_retry_reg && retry_tmr_reg[i] >= RETRY_CYC;
         // Override drops all lockouts except the standby supply one.
         main_gate[i] = !STANDBY_SUPPLY_IN_UV_I[i] && (force_on[i]
            || (card_reg[i] && MAIN_ENABLE_I[i] && !main_trip_reg[i]
                && !aux_trip_reg[i] && !MAIN_INPUT_UV_I[i]));
         aux_gate[i] = !STANDBY_SUPPLY_IN_UV_I[i] && (force_on[i]
            || (card_reg[i] && SLOT_STANDBY_ENABLE_I[i] && !aux_trip_reg[i]));
         slot_bad[i] = card_reg[i] && (MAIN_ENABLE_I[i] || SLOT_STANDBY_ENABLE_I[i])
            && !force_on[i] && !rails_good[i];
      end
      status_word = 32'h00000000;
      status_word[`DSHFC_ST_MAIN_TRIP+1:`DSHFC_ST_MAIN_TRIP] = main_trip_reg;
      status_word[`DSHFC_ST_AUX_TRIP+1:`DSHFC_ST_AUX_TRIP] = aux_trip_reg;
      status_word[`DSHFC_ST_CARD+1:`DSHFC_ST_CARD] = card_reg;
      status_word[`DSHFC_ST_POWER_OK+1:`DSHFC_ST_POWER_OK] = power_ok_reg;
      status_word[`DSHFC_ST_DELAY_OK+1:`DSHFC_ST_DELAY_OK] = delay_ok_reg;
      status_word[`DSHFC_ST_FORCE+1:`DSHFC_ST_FORCE] = force_on;
   end

   // Avalon slave: one wait cycle, then the answer stands for one cycle.
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= 32'h00000000;
         auto_retry_reg <= CTRL_RST[`DSHFC_CTRL_RETRY_BIT];
      end
      else
      begin
         if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O)
         begin
            AVS_WAITREQUEST_O <= 1'b0;
            if (AVS_READ_I && AVS_ADDRESS_I == `DSHFC_ADDR_CTRL)
            begin
               AVS_READDATA_O <= {31'h00000000, auto_retry_reg};
            end
            else if (AVS_READ_I && AVS_ADDRESS_I == `DSHFC_ADDR_STATUS)
            begin
               AVS_READDATA_O <= status_word;
            end
            else
            begin
               AVS_READDATA_O <= 32'h00000000;
            end
         end
         else
         begin
            AVS_WAITREQUEST_O <= 1'b1;
         end
         if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `DSHFC_ADDR_CTRL)
         begin
            auto_retry_reg <= AVS_WRITEDATA_I[`DSHFC_CTRL_RETRY_BIT];
         end
      end
   end

   // Slot state: timers, breakers, debounce and status pins.
   always @(posedge MCLK_I)
   begin : slot_seq_blk
      integer i;
      if (RESET_I)
      begin
         main_en_d_reg <= 2'h0;
         aux_en_d_reg <= 2'h0;
         card_reg <= 2'h0;
         main_trip_reg <= 2'h0;
         aux_trip_reg <= 2'h0;
         alert_reg <= 2'h0;
         power_ok_reg <= 2'h0;
         delay_ok_reg <= 2'h0;
         MAIN_HIGH_RAIL_OUT_EN_O <= 2'h0;
         MAIN_LOW_RAIL_OUT_EN_O <= 2'h0;
         STANDBY_RAIL_OUT_EN_O <= 2'h0;
         MAIN_FAULT_OE_O <= 2'h0;
         AUX_FAULT_OE_O <= 2'h0;
         SLOT_POWER_OK_N_OE_O <= 2'h0;
         DELAYED_POWER_OK_N_OE_O <= 2'h0;
         SYSTEM_POWER_OK_OE_O <= 1'b0;
         ALERT_OE_O <= 1'b0;
         for (i = 0; i < 2; i = i + 1)
         begin
            deb_cnt_reg[i] <= {CNT_W{1'b0}};
            main_tmr_reg[i] <= {CNT_W{1'b0}};
            aux_tmr_reg[i] <= {CNT_W{1'b0}};
            retry_tmr_reg[i] <= {CNT_W{1'b0}};
            dly_tmr_reg[i] <= {CNT_W{1'b0}};
         end
      end
      else
      begin
         main_en_d_reg <= MAIN_ENABLE_I;
         aux_en_d_reg <= SLOT_STANDBY_ENABLE_I;
         for (i = 0; i < 2; i = i + 1)
         begin
            // Latch level is adopted only after it differs for the full debounce time.
            deb_cnt_reg[i] <= step(card_reg[i] == CARD_LATCH_N_I[i], deb_cnt_reg[i],
               DEBOUNCE_CYC);
            if (card_reg[i] == CARD_LATCH_N_I[i] && deb_cnt_reg[i] >= DEBOUNCE_CYC)
            begin
               card_reg[i] <= ~CARD_LATCH_N_I[i];
            end
            main_tmr_reg[i] <= step(MAIN_OC_SLOW_I[i] && !main_trip_reg[i],
               main_tmr_reg[i], TRIP_CYC);
            aux_tmr_reg[i] <= step(AUX_OC_I[i] && !aux_trip_reg[i],
               aux_tmr_reg[i], TRIP_CYC);
            retry_tmr_reg[i] <= step(auto_retry_reg && (main_trip_reg[i] || aux_trip_reg[i])
               && !retry_done[i], retry_tmr_reg[i], RETRY_CYC);
            // Clears come first so a trip in the same cycle wins.
            if (main_fall[i] || retry_done[i])
            begin
               main_trip_reg[i] <= 1'b0;
            end
            if (aux_fall[i] || retry_done[i])
            begin
               aux_trip_reg[i] <= 1'b0;
            end
            if (main_fall[i] || aux_fall[i])
            begin
               alert_reg[i] <= 1'b0;
            end
            if (main_trip_now[i])
            begin
               main_trip_reg[i] <= 1'b1;
            end
            if (aux_trip_now[i])
            begin
               aux_trip_reg[i] <= 1'b1;
            end
            if ((main_trip_now[i] && !main_trip_reg[i]) || (aux_trip_now[i] && !aux_trip_reg[i]))
            begin
               alert_reg[i] <= 1'b1;
            end
            power_ok_reg[i] <= force_on[i] || (main_gate[i] && aux_gate[i] && rails_good[i]);
            dly_tmr_reg[i] <= step(power_ok_reg[i], dly_tmr_reg[i], DELAY_OK_CYC);
            delay_ok_reg[i] <= force_on[i] || (power_ok_reg[i]
               && dly_tmr_reg[i] >= DELAY_OK_CYC);
         end
         MAIN_HIGH_RAIL_OUT_EN_O <= main_gate;
         MAIN_LOW_RAIL_OUT_EN_O <= main_gate;
         STANDBY_RAIL_OUT_EN_O <= aux_gate;
         MAIN_FAULT_OE_O <= MAIN_ENABLE_I & main_trip_reg & ~force_on;
         AUX_FAULT_OE_O <= SLOT_STANDBY_ENABLE_I & aux_trip_reg & ~force_on;
         SLOT_POWER_OK_N_OE_O <= power_ok_reg;
         DELAYED_POWER_OK_N_OE_O <= delay_ok_reg;
         SYSTEM_POWER_OK_OE_O <= (|slot_bad) && !(|force_on);
         ALERT_OE_O <= (|alert_reg) && !(|force_on);
      end
   end

endmodule // dshfc_top

/* verif/dshfc_chk.sv */
// Purpose: Port assertions for the dual-slot fault control block.
// Assumes: Short delay parameters; slot A is bit 0.
// Notes: Bound into every dshfc_top.
`timescale 1ns/1ps
module dshfc_chk #(
   parameter int DELAY_OK_CYC = 30
)(
   input wire MCLK_I,
   input wire RESET_I,
   input wire [1:0] MAIN_ENABLE_I,
   input wire [1:0] SLOT_STANDBY_ENABLE_I,
   input wire [1:0] CARD_LATCH_N_I,
   input wire [1:0] FORCE_ON_N_I,
   input wire [1:0] MAIN_OC_FAST_I,
   input wire [1:0] MAIN_OC_SLOW_I,
   input wire [1:0] MAIN_INPUT_UV_I,
   input wire [1:0] STANDBY_SUPPLY_IN_UV_I,
   input wire [1:0] MAIN_HIGH_RAIL_OUT_EN_O,
   input wire [1:0] MAIN_LOW_RAIL_OUT_EN_O,
   input wire [1:0] STANDBY_RAIL_OUT_EN_O,
   input wire [1:0] MAIN_FAULT_OE_O,
   input wire [1:0] AUX_FAULT_OE_O,
   input wire [1:0] SLOT_POWER_OK_N_OE_O,
   input wire [1:0] DELAYED_POWER_OK_N_OE_O,
   input wire SYSTEM_POWER_OK_OE_O,
   input wire ALERT_OE_O
);
   default clocking @(posedge MCLK_I);
   endclocking
   default disable iff (RESET_I);
   logic [31:0] ok_cnt_reg;
   wire main_quiet = MAIN_ENABLE_I[0] && FORCE_ON_N_I[0] && !MAIN_OC_FAST_I[0]
      && !MAIN_OC_SLOW_I[0] && !MAIN_INPUT_UV_I[0];
   always_ff @(posedge MCLK_I)
      ok_cnt_reg <= (RESET_I || !SLOT_POWER_OK_N_OE_O[0]) ? 32'h0 : ok_cnt_reg + 32'h1;
   sequence s_forced;
      (!FORCE_ON_N_I[0] && !STANDBY_SUPPLY_IN_UV_I[0]) [*3];
   endsequence
   sequence s_fast;
      MAIN_ENABLE_I[0] && FORCE_ON_N_I[0] && MAIN_OC_FAST_I[0]
         ##1 MAIN_ENABLE_I[0] && FORCE_ON_N_I == 2'h3;
   endsequence
   property p_card;
      $rose(MAIN_HIGH_RAIL_OUT_EN_O[0]) && $past(FORCE_ON_N_I[0]) && $past(FORCE_ON_N_I[0], 2)
         |-> !$past(CARD_LATCH_N_I[0], 3);
   endproperty
   a_card: assert property (p_card) else $error("gate on without card");
   property p_force_on;
      s_forced |-> MAIN_HIGH_RAIL_OUT_EN_O[0] && MAIN_LOW_RAIL_OUT_EN_O[0] && STANDBY_RAIL_OUT_EN_O[0];
   endproperty
   a_force_on: assert property (p_force_on) else $error("forced slot off");
   property p_force_st;
      s_forced |-> SLOT_POWER_OK_N_OE_O[0] && DELAYED_POWER_OK_N_OE_O[0] && !MAIN_FAULT_OE_O[0]
         && !AUX_FAULT_OE_O[0] && !SYSTEM_POWER_OK_OE_O && !ALERT_OE_O;
   endproperty
   a_force_st: assert property (p_force_st) else $error("forced status wrong");
   property p_fast;
      s_fast |=> !MAIN_HIGH_RAIL_OUT_EN_O[0] && !MAIN_LOW_RAIL_OUT_EN_O[0] && MAIN_FAULT_OE_O[0]
         && ALERT_OE_O;
   endproperty
   a_fast: assert property (p_fast) else $error("fast trip late");
   property p_main_clear;
      ($rose(MAIN_ENABLE_I[0]) && main_quiet) ##1 main_quiet |=> !MAIN_FAULT_OE_O[0];
   endproperty
   a_main_clear: assert property (p_main_clear) else $error("fault not cleared");
   property p_aux_cut;
      $rose(AUX_FAULT_OE_O[0]) |-> !(STANDBY_RAIL_OUT_EN_O[0] || MAIN_HIGH_RAIL_OUT_EN_O[0]
         || MAIN_LOW_RAIL_OUT_EN_O[0]);
   endproperty
   a_aux_cut: assert property (p_aux_cut) else $error("rails on after aux trip");
   property p_delay;
      ok_cnt_reg == DELAY_OK_CYC + 6 |-> DELAYED_POWER_OK_N_OE_O[0];
   endproperty
   a_delay: assert property (p_delay) else $error("delayed ok missing");
   property p_idle;
      (MAIN_ENABLE_I == 2'h0 && SLOT_STANDBY_ENABLE_I == 2'h0) [*3] |-> !SYSTEM_POWER_OK_OE_O;
   endproperty
   a_idle: assert property (p_idle) else $error("system ok low when idle");
endmodule // dshfc_chk
bind dshfc_top dshfc_chk #(.DELAY_OK_CYC(DELAY_OK_CYC)) u_chk (.*);

/* verif/dshfc_host.sv */
// Purpose: Behavioural hot-plug controller driving the slot pins.
// Assumes: Enables are open-drain with pull-ups.
// Notes: Pins move one cycle after a command.
`timescale 1ns/1ps
module dshfc_host (
   input wire clk_i,
   input wire [1:0] main_off_i,
   input wire [1:0] aux_off_i,
   input wire [1:0] seat_i,
   output logic [1:0] main_en_o = 2'h0,
   output logic [1:0] aux_en_o = 2'h0,
   output logic [1:0] latch_n_o = 2'h3
);
   always @(posedge clk_i)
   begin
      main_en_o <= ~main_off_i;
      aux_en_o <= ~aux_off_i;
      latch_n_o <= ~seat_i;
   end
endmodule // dshfc_host

/* verif/dshfc_tb_top.sv */
// Purpose: Self-checking bench for dshfc_top.
// Assumes: Short delay parameters; slot A is bit 0.
// Notes: Enables and card latches come from the host model.
`timescale 1ns/1ps
module dshfc_tb_top;
   localparam [25:0] TC = 26'h14;
   localparam [25:0] RC = 26'h28;
   localparam [25:0] DC = 26'h8;
   localparam [25:0] OC = 26'h1e;
   logic MCLK_I, RESET_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O, DIE_HOT_I;
   logic SYSTEM_POWER_OK_OE_O, ALERT_OE_O;
   logic [3:0] AVS_ADDRESS_I;
   logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, rd;
   logic [1:0] FORCE_ON_N_I, MAIN_OC_SLOW_I, MAIN_OC_FAST_I, AUX_OC_I, SLOT_HOT_I;
   logic [1:0] FILTER_CAP_TIMEOUT_I, FILTER_CAP_PIN_GROUNDED_I, MAIN_INPUT_UV_I;
   logic [1:0] STANDBY_SUPPLY_IN_UV_I, MAIN_HIGH_RAIL_GOOD_I, MAIN_LOW_RAIL_GOOD_I;
   logic [1:0] STANDBY_RAIL_GOOD_I, MAIN_HIGH_RAIL_OUT_EN_O, MAIN_LOW_RAIL_OUT_EN_O;
   logic [1:0] STANDBY_RAIL_OUT_EN_O, MAIN_FAULT_OE_O, AUX_FAULT_OE_O, SLOT_POWER_OK_N_OE_O;
   logic [1:0] DELAYED_POWER_OK_N_OE_O, MAIN_ENABLE_I, SLOT_STANDBY_ENABLE_I, CARD_LATCH_N_I;
   logic [1:0] m_off, a_off, seat;
   int failures, checks_done;
   dshfc_top #(.TRIP_CYC(TC), .RETRY_CYC(RC), .DEBOUNCE_CYC(DC), .DELAY_OK_CYC(OC)) u_dut (.*);
   dshfc_host u_host (.clk_i(MCLK_I), .main_off_i(m_off), .aux_off_i(a_off), .seat_i(seat),
      .main_en_o(MAIN_ENABLE_I), .aux_en_o(SLOT_STANDBY_ENABLE_I), .latch_n_o(CARD_LATCH_N_I));
   initial
   begin
      MCLK_I = 1'b0;
      forever #10 MCLK_I = ~MCLK_I;
   end
   task automatic cy(input int n);
      repeat (n) @(posedge MCLK_I);
   endtask
   task automatic chk(input [31:0] g, input [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input bit w, input [3:0] a, input [31:0] d);
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= d;
      AVS_WRITE_I <= w;
      AVS_READ_I <= !w;
      @(posedge MCLK_I);
      while (AVS_WAITREQUEST_O !== 1'b0)
         @(posedge MCLK_I);
      rd = AVS_READDATA_O;
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
      cy(1);
   endtask
   function automatic [31:0] st(input int s);
      st = {25'h0, MAIN_HIGH_RAIL_OUT_EN_O[s], MAIN_LOW_RAIL_OUT_EN_O[s], STANDBY_RAIL_OUT_EN_O[s],
         MAIN_FAULT_OE_O[s], AUX_FAULT_OE_O[s], SLOT_POWER_OK_N_OE_O[s], DELAYED_POWER_OK_N_OE_O[s]};
   endfunction
   task automatic results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      cy(2000);
      failures++;
      results();
   end
   initial
   begin
      failures = 0;
      checks_done = 0;
      {RESET_I, m_off, a_off, seat} = 7'h7c;
      {AVS_READ_I, AVS_WRITE_I, DIE_HOT_I, AVS_ADDRESS_I, AVS_WRITEDATA_I} = 39'h0;
      {MAIN_OC_SLOW_I, MAIN_OC_FAST_I, AUX_OC_I, SLOT_HOT_I, FILTER_CAP_TIMEOUT_I} = 10'h0;
      {FILTER_CAP_PIN_GROUNDED_I, MAIN_INPUT_UV_I, STANDBY_SUPPLY_IN_UV_I} = 6'h0;
      {FORCE_ON_N_I, MAIN_HIGH_RAIL_GOOD_I, MAIN_LOW_RAIL_GOOD_I, STANDBY_RAIL_GOOD_I} = 8'hff;
      cy(5);
      RESET_I <= 1'b0;
      cy(4);
      chk({30'h0, SYSTEM_POWER_OK_OE_O, ALERT_OE_O}, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 4'h4, 32'hfff);
      bus(1'b1, 4'h8, 32'h1);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0);
      {m_off, a_off, seat} <= 6'h03;
      cy(4);
      chk(st(0), 32'h0);
      cy(DC + 8);
      chk(st(0), 32'h72);
      cy(OC - 12);
      chk(st(0), 32'h72);
      cy(12);
      chk(st(1), 32'h73);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h3f0);
      MAIN_OC_FAST_I <= 2'h1;
      cy(1);
      MAIN_OC_FAST_I <= 2'h0;
      cy(RC + 9);
      chk(st(0) & 32'h78, 32'h18);
      chk(st(1), 32'h73);
      m_off <= 2'h1;
      cy(4);
      chk({31'h0, ALERT_OE_O}, 32'h0);
      m_off <= 2'h0;
      cy(4);
      chk(st(0) & 32'h78, 32'h70);
      {AUX_OC_I, SLOT_HOT_I} <= 4'h5;
      cy(4);
      chk(st(0) & 32'h7c, 32'h04);
      chk(st(1) & 32'h7c, 32'h70);
      {AUX_OC_I, SLOT_HOT_I, a_off} <= 6'h01;
      cy(4);
      chk(st(0) & 32'h04, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      {FILTER_CAP_PIN_GROUNDED_I, FILTER_CAP_TIMEOUT_I, MAIN_OC_SLOW_I, a_off} <= 8'hbe;
      cy(TC - 3);
      chk(st(1) & 32'h08, 32'h0);
      chk(st(0) & 32'h6c, 32'h08);
      cy(8);
      chk(st(1) & 32'h68, 32'h08);
      {FILTER_CAP_TIMEOUT_I, MAIN_OC_SLOW_I} <= 4'h0;
      cy(RC + 6);
      chk(st(1) & 32'h68, 32'h60);
      chk(st(0) & 32'h6c, 32'h60);
      {MAIN_OC_SLOW_I, MAIN_INPUT_UV_I, FORCE_ON_N_I} <= 6'h16;
      cy(4);
      chk(st(0), 32'h73);
      chk({30'h0, SYSTEM_POWER_OK_OE_O, ALERT_OE_O}, 32'h0);
      {FORCE_ON_N_I, MAIN_INPUT_UV_I, MAIN_OC_SLOW_I, MAIN_HIGH_RAIL_GOOD_I} <= 8'hc2;
      cy(4);
      chk({30'h0, SYSTEM_POWER_OK_OE_O, ALERT_OE_O}, 32'h3);
      {DIE_HOT_I, a_off, MAIN_HIGH_RAIL_GOOD_I} <= 5'h13;
      cy(5);
      chk(st(0) & 32'h7c, 32'h04);
      chk(st(1) & 32'h7c, 32'h04);
      results();
   end
endmodule // dshfc_tb_top
